// file: hw/scm_pkg.sv
// constants and types shared by the system clock mode control block
package scm_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [3:0] SCM_MODE_CTRL_ADDR = 4'h0;
   localparam logic [3:0] SCM_FAST_CTRL_ADDR = 4'h1;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int         SCM_SEL_LSB      = 5;
   localparam int         SCM_SEL_MSB      = 7;
   localparam int         SCM_FIDLE_BIT    = 1;
   localparam int         SCM_SIDLE_BIT    = 0;
   localparam int         SCM_STABLE_BIT   = 1;
   localparam int         SCM_FEN_BIT      = 0;
   localparam logic [7:0] SCM_MODE_CTRL_RST = 8'h00;
   localparam logic [7:0] SCM_FAST_CTRL_RST = 8'h01;
   localparam logic [2:0] SCM_SEL_SLOW      = 3'h7;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int SCM_CLK_PERIOD_NS   = 50;
   localparam int SCM_FAST_STABLE_NS  = 16000;
   localparam int SCM_FAST_STABLE_CYC =
      (SCM_FAST_STABLE_NS + SCM_CLK_PERIOD_NS - 1) / SCM_CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // operating modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SCM_NORMAL,
      SCM_SLOW,
      SCM_SLEEP,
      SCM_IDLE_SLOW_ONLY,
      SCM_IDLE_BOTH_CLOCKS,
      SCM_IDLE_FAST_ONLY
   } scm_mode_t;
endpackage

// file: hw/scm_divider.sv
// fast clock tick divider, divide ratio changes only at a period boundary
`timescale 1ns/1ps
module scm_divider
   import scm_pkg::*;
#(
   parameter int DIV_W = 6
) (
   input  wire logic       clk_sys,    // system clock
   input  wire logic       reset_n,    // async reset, active low
   input  wire logic       tick_in,    // one pulse per fast clock cycle
   input  wire logic [2:0] div_code,   // requested divide code 0..6
   output logic            tick_out_r, // divided tick
   output logic            boundary_r  // period just completed
);
   logic [DIV_W-1:0] cnt_r;
   logic [2:0]       code_r;
   logic [DIV_W-1:0] mask;
   logic             wrap;

   // a new ratio is latched only at wrap, so no period is ever shortened
   assign mask = DIV_W'((7'h01 << code_r) - 7'h01);
   assign wrap = tick_in && ((cnt_r & mask) == mask);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r      <= '0;
         code_r     <= 3'h0;
         tick_out_r <= 1'b0;
         boundary_r <= 1'b1;
      end else begin
         tick_out_r <= wrap;
         if (wrap) begin
            cnt_r      <= '0;
            code_r     <= div_code;
            boundary_r <= 1'b1;
         end else if (tick_in) begin
            cnt_r      <= cnt_r + 1'b1;
            boundary_r <= 1'b0;
         end
      end
   end
endmodule

// file: hw/scm_top.sv
// system clock source selection and power-down mode control
`timescale 1ns/1ps

module scm_top
   import scm_pkg::*;
#(
   parameter int STABLE_CYC = SCM_FAST_STABLE_CYC
) (
   input  wire logic       clk_sys,        // system clock, 20 MHz
   input  wire logic       reset_n,        // async reset, active low
   input  wire logic [3:0] reg_addr,       // register address
   input  wire logic [7:0] reg_wdata,      // register write data
   input  wire logic       reg_wr,         // write strobe
   input  wire logic       reg_rd,         // read strobe
   output logic [7:0]      reg_rdata_r,    // read data, cycle after strobe
   input  wire logic       fast_tick,      // fast oscillator cycle pulse
   input  wire logic       slow_tick,      // slow oscillator cycle pulse
   input  wire logic       low_speed_rc_oscillator_stable,    // low-speed oscillator stable
   input  wire logic       halt_exec,      // stop instruction executed
   input  wire logic       wake_req,       // wake-up event
   output logic            sys_tick_r,     // system clock tick
   output logic            fast_periph_r,  // fast tick for peripherals
   output logic            fast_osc_on_r,  // fast oscillator enable
   output logic            slow_clk_on_r,  // slow peripheral clock on
   output logic            low_speed_rc_oscillator_on_r,      // low-speed oscillator on
   output logic            cpu_run_r,      // cpu clocked
   output logic            hold_state_r,   // freeze memory, regs, ports
   output logic            pdf_set_r,      // set power-down flag pulse
   output logic            to_clr_r,       // clear timeout flag pulse
   output logic            wdt_clr_r,      // clear watchdog pulse
   output scm_mode_t       mode_r          // current operating mode
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [2:0]  clock_select_field_r;
   logic        fast_idle_enable_r;
   logic        slow_idle_enable_r;
   logic        fast_osc_enable_r;
   logic        fast_osc_stable_flag_r;
   logic        src_slow_r;
   logic [15:0] stab_cnt_r;
   scm_mode_t   mode_nxt;

   logic        wr_mode;
   logic        wr_fast;
   logic        running;
   logic        want_slow;
   logic        div_tick;
   logic        div_boundary;
   logic        to_slow_ok;
   logic        to_fast_ok;
   logic        fast_on_nxt;
   logic        slow_on_nxt;
   logic        sys_run_nxt;
   logic        halt_go;
   logic [7:0]  mode_rd;
   logic [7:0]  fast_rd;
   logic [7:0]  rd_nxt;

   function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] b);
      addr_hit = (a == b);
   endfunction

   // ----------------------------------------------------------------
   // register access
   // ----------------------------------------------------------------
   assign running = (mode_r == SCM_NORMAL) || (mode_r == SCM_SLOW);
   // cpu is off when powered down, so writes arriving then are ignored
   assign wr_mode = reg_wr && running && addr_hit(reg_addr, SCM_MODE_CTRL_ADDR);
   assign wr_fast = reg_wr && running && addr_hit(reg_addr, SCM_FAST_CTRL_ADDR);

   assign mode_rd = {clock_select_field_r, 3'h0, fast_idle_enable_r, slow_idle_enable_r};
   assign fast_rd = {6'h00, fast_osc_stable_flag_r, fast_osc_enable_r};
   assign rd_nxt  = !reg_rd ? 8'h00 :
                    addr_hit(reg_addr, SCM_MODE_CTRL_ADDR) ? mode_rd :
                    addr_hit(reg_addr, SCM_FAST_CTRL_ADDR) ? fast_rd : 8'h00;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         clock_select_field_r <= SCM_MODE_CTRL_RST[SCM_SEL_MSB:SCM_SEL_LSB];
         fast_idle_enable_r   <= SCM_MODE_CTRL_RST[SCM_FIDLE_BIT];
         slow_idle_enable_r   <= SCM_MODE_CTRL_RST[SCM_SIDLE_BIT];
         fast_osc_enable_r    <= SCM_FAST_CTRL_RST[SCM_FEN_BIT];
         reg_rdata_r          <= 8'h00;
      end else begin
         reg_rdata_r <= rd_nxt;
         if (wr_mode) begin
            clock_select_field_r <= reg_wdata[SCM_SEL_MSB:SCM_SEL_LSB];
            fast_idle_enable_r   <= reg_wdata[SCM_FIDLE_BIT];
            slow_idle_enable_r   <= reg_wdata[SCM_SIDLE_BIT];
         end
         if (wr_fast)
            fast_osc_enable_r <= reg_wdata[SCM_FEN_BIT];
      end
   end

   // ----------------------------------------------------------------
   // fast oscillator stabilisation
   // ----------------------------------------------------------------
   // flag drops whenever the oscillator is off, so an enable from 0 to 1
   // always sees 0 first and 1 only after the full settle time
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         stab_cnt_r             <= 16'h0000;
         fast_osc_stable_flag_r <= 1'b0;
      end else if (!fast_osc_on_r || (wr_fast && !fast_osc_enable_r &&
                                      reg_wdata[SCM_FEN_BIT])) begin
         stab_cnt_r             <= 16'h0000;
         fast_osc_stable_flag_r <= 1'b0;
      end else if (stab_cnt_r >= 16'(STABLE_CYC - 1)) begin
         fast_osc_stable_flag_r <= 1'b1;
      end else begin
         stab_cnt_r <= stab_cnt_r + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // clock source switching
   // ----------------------------------------------------------------
   scm_divider u_div (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .tick_in    (fast_tick && fast_osc_stable_flag_r),
      .div_code   (want_slow ? 3'h0 : clock_select_field_r),
      .tick_out_r (div_tick),
      .boundary_r (div_boundary)
   );

   assign want_slow = (clock_select_field_r == SCM_SEL_SLOW);
   // switch only at the end of a whole period of the old source
   assign to_slow_ok = want_slow && !src_slow_r && low_speed_rc_oscillator_stable && div_boundary;
   assign to_fast_ok = !want_slow && src_slow_r && fast_osc_stable_flag_r
                       && slow_tick;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         src_slow_r <= 1'b0;
      else if (to_slow_ok)
         src_slow_r <= 1'b1;
      else if (to_fast_ok)
         src_slow_r <= 1'b0;
   end

   // ----------------------------------------------------------------
   // operating mode
   // ----------------------------------------------------------------
   assign halt_go = halt_exec && running;

   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         SCM_NORMAL, SCM_SLOW: begin
            if (halt_go) begin
               case ({fast_idle_enable_r, slow_idle_enable_r})
                  2'b00:   mode_nxt = SCM_SLEEP;
                  2'b01:   mode_nxt = SCM_IDLE_SLOW_ONLY;
                  2'b11:   mode_nxt = SCM_IDLE_BOTH_CLOCKS;
                  default: mode_nxt = SCM_IDLE_FAST_ONLY;
               endcase
            end else begin
               mode_nxt = src_slow_r ? SCM_SLOW : SCM_NORMAL;
            end
         end
         SCM_SLEEP, SCM_IDLE_SLOW_ONLY, SCM_IDLE_BOTH_CLOCKS, SCM_IDLE_FAST_ONLY: begin
            if (wake_req)
               mode_nxt = src_slow_r ? SCM_SLOW : SCM_NORMAL;
         end
         default: mode_nxt = SCM_NORMAL;
      endcase
   end

   // ----------------------------------------------------------------
   // clock gating per mode
   // ----------------------------------------------------------------
   always_comb begin
      fast_on_nxt = 1'b1;
      slow_on_nxt = 1'b1;
      sys_run_nxt = 1'b1;
      case (mode_nxt)
         SCM_NORMAL: begin
            // fast must run until the switch away from it is complete
            fast_on_nxt = 1'b1;
         end
         SCM_SLOW: begin
            // keep fast alive while a return to it is pending
            fast_on_nxt = fast_osc_enable_r || !want_slow;
         end
         SCM_SLEEP: begin
            fast_on_nxt = 1'b0;
            slow_on_nxt = 1'b0;
            sys_run_nxt = 1'b0;
         end
         SCM_IDLE_SLOW_ONLY: begin
            fast_on_nxt = 1'b0;
            sys_run_nxt = src_slow_r;
         end
         SCM_IDLE_BOTH_CLOCKS: begin
            fast_on_nxt = 1'b1;
         end
         SCM_IDLE_FAST_ONLY: begin
            slow_on_nxt = 1'b0;
            sys_run_nxt = !src_slow_r;
         end
         default: begin
            fast_on_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode_r        <= SCM_NORMAL;
         fast_osc_on_r <= 1'b1;
         slow_clk_on_r <= 1'b1;
         low_speed_rc_oscillator_on_r     <= 1'b1;
         cpu_run_r     <= 1'b1;
         hold_state_r  <= 1'b0;
         sys_tick_r    <= 1'b0;
         fast_periph_r <= 1'b0;
         pdf_set_r     <= 1'b0;
         to_clr_r      <= 1'b0;
         wdt_clr_r     <= 1'b0;
      end else begin
         mode_r        <= mode_nxt;
         fast_osc_on_r <= fast_on_nxt;
         slow_clk_on_r <= slow_on_nxt;
         low_speed_rc_oscillator_on_r     <= 1'b1;
         cpu_run_r     <= (mode_nxt == SCM_NORMAL) || (mode_nxt == SCM_SLOW);
         hold_state_r  <= !((mode_nxt == SCM_NORMAL) || (mode_nxt == SCM_SLOW));
         // tick follows the source that is actually in use
         sys_tick_r    <= sys_run_nxt && (src_slow_r ? slow_tick : div_tick);
         fast_periph_r <= fast_tick && fast_osc_on_r;
         pdf_set_r     <= halt_go;
         to_clr_r      <= halt_go;
         wdt_clr_r     <= halt_go;
      end
   end
endmodule

// file: tb/scm_top_props.sv
// concurrent checks on the clock mode control ports
`timescale 1ns/1ps
module scm_top_props
   import scm_pkg::*;
(
   input wire logic       clk_sys,       // clock
   input wire logic       reset_n,       // reset, active low
   input wire logic [3:0] reg_addr,      // address
   input wire logic       reg_rd,        // read strobe
   input wire logic [7:0] reg_rdata_r,   // read data
   input wire logic       low_speed_rc_oscillator_stable,   // slow osc stable
   input wire logic       halt_exec,     // stop instruction
   input wire logic       wake_req,      // wake event
   input wire logic       fast_osc_on_r, // fast osc on
   input wire logic       slow_clk_on_r, // slow clock on
   input wire logic       low_speed_rc_oscillator_on_r,     // low-speed osc on
   input wire logic       cpu_run_r,     // cpu clocked
   input wire logic       hold_state_r,  // frozen state
   input wire logic       pdf_set_r,     // power-down set
   input wire logic       to_clr_r,      // timeout clear
   input wire logic       wdt_clr_r,     // watchdog clear
   input wire scm_mode_t  mode_r         // mode
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire down = (mode_r >= SCM_SLEEP);

   a_halt_flags: assert property (halt_exec && !down |=> pdf_set_r && to_clr_r && wdt_clr_r)
      else $error("halt gave no power-down pulses");
   a_pulse_once: assert property (pdf_set_r |-> $past(halt_exec) ##1 !pdf_set_r && !wdt_clr_r)
      else $error("power-down pulse wrong");
   a_sleep_clocks: assert property (mode_r == SCM_SLEEP |->
      !fast_osc_on_r && !slow_clk_on_r && low_speed_rc_oscillator_on_r)
      else $error("sleep clocks wrong");
   a_idle_slow: assert property (mode_r == SCM_IDLE_SLOW_ONLY |-> !fast_osc_on_r && slow_clk_on_r)
      else $error("slow-only idle clocks wrong");
   a_idle_both: assert property (mode_r == SCM_IDLE_BOTH_CLOCKS |->
      fast_osc_on_r && slow_clk_on_r && low_speed_rc_oscillator_on_r)
      else $error("both-clock idle clocks wrong");
   a_idle_fast: assert property (mode_r == SCM_IDLE_FAST_ONLY |-> fast_osc_on_r && !slow_clk_on_r)
      else $error("fast-only idle clocks wrong");
   a_normal_all: assert property (mode_r == SCM_NORMAL |->
      cpu_run_r && fast_osc_on_r && slow_clk_on_r && low_speed_rc_oscillator_on_r)
      else $error("normal mode clocks wrong");
   a_down_hold: assert property (down |-> hold_state_r && !cpu_run_r)
      else $error("state not held while down");
   a_mode_stay: assert property (down && !wake_req |=> $stable(mode_r))
      else $error("mode left without wake");
   a_upper_zero: assert property (reg_rd && reg_addr == SCM_FAST_CTRL_ADDR |=>
      reg_rdata_r[7:2] == 6'h00)
      else $error("upper bits not zero");
   a_slow_wait: assert property (mode_r == SCM_NORMAL && !low_speed_rc_oscillator_stable && !$past(low_speed_rc_oscillator_stable)
      |=> mode_r != SCM_SLOW)
      else $error("slow entered before oscillator stable");

   c_slow: cover property (mode_r == SCM_SLOW);
   c_idle_both: cover property (mode_r == SCM_IDLE_BOTH_CLOCKS);
   c_halt: cover property (halt_exec && !down);
endmodule

bind scm_top scm_top_props u_props (.clk_sys, .reset_n, .reg_addr, .reg_rd, .reg_rdata_r,
   .low_speed_rc_oscillator_stable, .halt_exec, .wake_req, .fast_osc_on_r, .slow_clk_on_r, .low_speed_rc_oscillator_on_r,
   .cpu_run_r, .hold_state_r, .pdf_set_r, .to_clr_r, .wdt_clr_r, .mode_r);

// file: tb/scm_top_bench.sv
// self-checking bench for the clock mode control block
`timescale 1ns/1ps
module scm_top_bench
   import scm_pkg::*;
;
   // ----------------------------------------------------------------
   // signals and design
   // ----------------------------------------------------------------
   localparam int         STB = 4;
   // {idle bits, mode, fast on, slow on, sys runs} with select code 0
   localparam logic [7:0] ROWS [4] = '{8'h10, 8'h5A, 8'hE7, 8'hAD};
   logic       clk_sys, reset_n, reg_wr, reg_rd, fast_tick, slow_tick;
   logic       low_speed_rc_oscillator_stable, halt_exec, wake_req, sys_tick_r, fast_periph_r;
   logic       fast_osc_on_r, slow_clk_on_r, low_speed_rc_oscillator_on_r, cpu_run_r, hold_state_r;
   logic       pdf_set_r, to_clr_r, wdt_clr_r;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata_r, got;
   scm_mode_t  mode_r;
   int         n_fail = 0, check_count = 0, cyc = 0, gap, pgap;

   scm_top #(.STABLE_CYC(STB)) DUT (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata_r, .fast_tick, .slow_tick, .low_speed_rc_oscillator_stable, .halt_exec, .wake_req,
      .sys_tick_r, .fast_periph_r, .fast_osc_on_r, .slow_clk_on_r, .low_speed_rc_oscillator_on_r, .cpu_run_r,
      .hold_state_r, .pdf_set_r, .to_clr_r, .wdt_clr_r, .mode_r);

   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end
   // fast oscillator every second cycle, slow one every sixteenth
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      fast_tick <= cyc[0];
      slow_tick <= (cyc[3:0] == 4'hF);
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(string name, logic [7:0] exp, logic [7:0] seen);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(logic [3:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1 got = reg_rdata_r;
   endtask
   task automatic strobe(logic h, logic w);
      @(posedge clk_sys);
      halt_exec <= h;
      wake_req <= w;
      @(posedge clk_sys);
      halt_exec <= 1'h0;
      wake_req <= 1'h0;
      #1;
   endtask
   task automatic wait_mode(scm_mode_t m);
      repeat (400) if (mode_r !== m) @(posedge clk_sys);
      #1;
   endtask
   // 48 cycles hold a whole number of fast and slow tick periods, so counts never depend on phase
   task automatic count_ticks();
      gap = 0;
      pgap = 0;
      repeat (48) begin
         @(posedge clk_sys);
         #1 gap += (sys_tick_r === 1'h1);
         pgap += (fast_periph_r === 1'h1);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      {reset_n, reg_wr, reg_rd, halt_exec, wake_req, low_speed_rc_oscillator_stable} = 6'h00;
      {reg_addr, reg_wdata} = 12'h000;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'h1;
      rd(SCM_FAST_CTRL_ADDR);
      chk("fast ctrl", SCM_FAST_CTRL_RST, got);
      rd(SCM_MODE_CTRL_ADDR);
      chk("mode ctrl", SCM_MODE_CTRL_RST, got);
      wr(4'h5, 8'hFF);
      rd(4'h5);
      chk("unmapped", 8'h00, got);
      wr(SCM_FAST_CTRL_ADDR, 8'hFF);
      repeat (STB + 2) @(posedge clk_sys);
      rd(SCM_FAST_CTRL_ADDR);
      chk("fast ctrl", 8'h03, got);
      $display("reset test done");
      foreach (ROWS[i]) begin
         wr(SCM_MODE_CTRL_ADDR, {6'h00, ROWS[i][7:6]});
         strobe(1'h1, 1'h0);
         chk("mode", ROWS[i][5:3], mode_r);
         chk("clocks", {ROWS[i][2:1], 1'h1}, {fast_osc_on_r, slow_clk_on_r, low_speed_rc_oscillator_on_r});
         chk("halt outs", 8'h0F, {cpu_run_r, hold_state_r, pdf_set_r, to_clr_r, wdt_clr_r});
         wr(SCM_MODE_CTRL_ADDR, 8'hE3);
         count_ticks();
         chk("sys ticks", ROWS[i][0] ? 8'h18 : 8'h00, 8'(gap));
         chk("periph ticks", ROWS[i][2] ? 8'h18 : 8'h00, 8'(pgap));
         strobe(1'h0, 1'h1);
         chk("mode", SCM_NORMAL, mode_r);
         rd(SCM_MODE_CTRL_ADDR);
         chk("mode ctrl", {6'h00, ROWS[i][7:6]}, got);
      end
      $display("mode table test done");
      for (int k = 0; k < 7; k++) begin
         wr(SCM_MODE_CTRL_ADDR, 8'(k << SCM_SEL_LSB));
         repeat (300) @(posedge clk_sys);
         do begin @(posedge clk_sys); #1; end while (sys_tick_r !== 1'h1);
         gap = 0;
         do begin @(posedge clk_sys); #1 gap++; end while (sys_tick_r !== 1'h1);
         chk("tick gap", 8'(2 << k), 8'(gap));
      end
      $display("divider test done");
      wr(SCM_MODE_CTRL_ADDR, 8'hE0);
      repeat (40) @(posedge clk_sys);
      #1 chk("mode", SCM_NORMAL, mode_r);
      @(posedge clk_sys);
      low_speed_rc_oscillator_stable <= 1'h1;
      wait_mode(SCM_SLOW);
      chk("mode", SCM_SLOW, mode_r);
      // halt from slow: system clock keeps running on the slow source
      wr(SCM_MODE_CTRL_ADDR, 8'hE1);
      strobe(1'h1, 1'h0);
      chk("mode", SCM_IDLE_SLOW_ONLY, mode_r);
      count_ticks();
      chk("sys ticks", 8'h03, 8'(gap));
      chk("periph ticks", 8'h00, 8'(pgap));
      strobe(1'h0, 1'h1);
      chk("mode", SCM_SLOW, mode_r);
      wr(SCM_FAST_CTRL_ADDR, 8'h00);
      repeat (3) @(posedge clk_sys);
      #1 chk("fast on", 8'h00, fast_osc_on_r);
      count_ticks();
      chk("periph ticks", 8'h00, 8'(pgap));
      wr(SCM_MODE_CTRL_ADDR, 8'h00);
      rd(SCM_FAST_CTRL_ADDR);
      chk("fast ctrl", 8'h00, got);
      chk("mode", SCM_SLOW, mode_r);
      wait_mode(SCM_NORMAL);
      chk("mode", SCM_NORMAL, mode_r);
      $display("slow switch test done");
      wr(SCM_FAST_CTRL_ADDR, 8'h01);
      rd(SCM_FAST_CTRL_ADDR);
      chk("fast ctrl", 8'h01, got);
      do rd(SCM_FAST_CTRL_ADDR); while (got[1] !== 1'h1);
      chk("fast ctrl", 8'h03, got);
      $display("stable flag test done");
      // reset taken while powered down must bring back the run mode and reset values
      wr(SCM_MODE_CTRL_ADDR, 8'hC2);
      strobe(1'h1, 1'h0);
      chk("mode", SCM_IDLE_FAST_ONLY, mode_r);
      @(posedge clk_sys);
      reset_n <= 1'h0;
      repeat (2) @(posedge clk_sys);
      chk("reset outs", 8'h10, {cpu_run_r, hold_state_r, pdf_set_r, to_clr_r, wdt_clr_r});
      chk("mode", SCM_NORMAL, mode_r);
      reset_n <= 1'h1;
      rd(SCM_FAST_CTRL_ADDR);
      chk("fast ctrl", SCM_FAST_CTRL_RST, got);
      rd(SCM_MODE_CTRL_ADDR);
      chk("mode ctrl", SCM_MODE_CTRL_RST, got);
      $display("mid-run reset test done");
      print_verdict();
   end
endmodule
